// File: rtl/nbs_buf2.v
// Two-entry cycle buffer with registered outputs
`timescale 1ns/10ps
module nbs_buf2 (
   input wire ref_clk, // Bus clock
   input wire rst, // Synchronous reset, high
   input wire in_valid, // Producer has a word
   output wire in_ready, // Room for a word
   input wire [67:0] in_data, // Word from producer
   output reg out_valid, // Head entry valid
   input wire out_ready, // Consumer takes head
   output reg [67:0] out_data // Head entry
);
   // ------------------------------------------------------------
   // Storage and occupancy
   // ------------------------------------------------------------
   reg [67:0] tail; // Second entry
   reg [1:0] count; // Entries held, 0 to 2
   reg [1:0] next_count; // Occupancy after this edge
   wire push; // Word enters
   wire pop; // Word leaves
   // Full is honest: the producer stalls with two words held
   assign in_ready = (count != 2'h2);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   // Occupancy after this edge
   always @* begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 2'h1;
      end else if (pop && !push) begin
         next_count = count - 2'h1;
      end
   end
   // Head stays in a flop so the output has no mux after it
   always @(posedge ref_clk) begin
      if (rst) begin
         count <= 2'h0;
         out_valid <= 1'b0;
         out_data <= {68{1'b0}};
         tail <= {68{1'b0}};
      end else begin
         count <= next_count;
         out_valid <= (next_count != 2'h0);
         if (push && !pop) begin
            // Fill head first, then tail
            if (count == 2'h0) begin
               out_data <= in_data;
            end else begin
               tail <= in_data;
            end
         end else if (pop && !push) begin
            // Tail moves up
            out_data <= tail;
         end else if (pop && push) begin
            // Pass-through or shift with refill
            if (count == 2'h1) begin
               out_data <= in_data;
            end else begin
               out_data <= tail;
               tail <= in_data;
            end
         end
      end
   end
endmodule // nbs_buf2

// File: rtl/nbs_map.vh
// Constants shared by the narrow bus sizing block and its testbench
`ifndef NBS_MAP_VH
`define NBS_MAP_VH
// ------------------------------------------------------------
// Operand length codes on req_len
// ------------------------------------------------------------
`define NBS_LEN_1 2'h1
`define NBS_LEN_2 2'h2
`define NBS_LEN_4 2'h3
// ------------------------------------------------------------
// Byte masks for each operand length, before shifting by offset, and fixed lane masks
// ------------------------------------------------------------
`define NBS_MASK_1 8'h01
`define NBS_MASK_2 8'h03
`define NBS_MASK_4 8'h0f
`define NBS_MASK_NONE 4'h0
`define NBS_MASK_ALL 4'hf
`define NBS_MASK_LO16 4'h3
`define NBS_MASK_HI16 4'hc
// ------------------------------------------------------------
// Bus size codes after sampling the size pins
// ------------------------------------------------------------
`define NBS_SIZE_32 2'h0
`define NBS_SIZE_16 2'h1
`define NBS_SIZE_8 2'h2
// ------------------------------------------------------------
// Cache line fill shape
// ------------------------------------------------------------
`define NBS_FILL_DWORDS 3'h4
`define NBS_FILL_MAX_CYCLES 16
// ------------------------------------------------------------
// Cycle buffer payload: addr[31:2] 30, enables 4, wdata 32, write 1, first fill 1
// ------------------------------------------------------------
`define NBS_BUF_WIDTH 68
`endif

// File: rtl/nbs_sizer.v
// Splits processor operands and line fills into 32, 16 and 8-bit bus cycles
// Functional notes
// - Enables always contiguous and never all off
// - Bus size honoured during line fills
// - Byte-bus line fill needs at most sixteen cycles
// - Later fill cycles enable only missing bytes
// - Doublewords start at multiples of four
// - Boundary-crossing operands use extra cycles
// - Split internal transfers go high part first
// - Four bytes at offset three: upper three first
// - Wide-bus cycle count per length and offset
// - Narrow buses split by length and offset
// - Size-forced extra cycles go low part first
// - Four bytes on half bus: low word first
`include "nbs_map.vh"
`timescale 1ns/10ps
module nbs_sizer (
   input wire ref_clk, // 20 MHz bus clock
   input wire rst, // Synchronous reset, high
   input wire req_valid, // Operand or fill request
   output reg req_ready, // Idle, takes request
   input wire [31:0] req_addr, // Byte address
   input wire [1:0] req_len, // Operand length code
   input wire req_write, // Write when high
   input wire req_fill, // Cache line fill
   input wire [31:0] req_wdata, // Operand, low byte first
   output wire cyc_valid, // Bus cycle pending
   input wire cyc_ready, // Bus engine takes cycle
   output wire [31:2] cyc_addr, // Doubleword address
   output wire [3:0] byte_lane_enables_n, // Active-low enables
   output wire cyc_write, // Cycle direction
   output wire [31:0] cyc_wdata, // Write data on processor lanes
   output wire cyc_first_fill, // First cycle of a line fill
   input wire cyc_done, // Bus engine finished cycle
   input wire [31:0] cyc_rdata, // Read data on processor lanes
   input wire size8_request_n, // Byte bus size pin, low
   input wire size16_request_n, // Half bus size pin, low
   output reg rd_valid, // Read word ready
   output reg [31:0] rd_data, // Operand or fill dword
   output reg rd_last, // Last word of the request
   output reg op_done // Request complete pulse
);
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam ST_IDLE = 2'h0; // Waiting for request
   localparam ST_ISSUE = 2'h1; // Pushing a cycle
   localparam ST_WAIT = 2'h2; // Cycle on the bus
   // ------------------------------------------------------------
   // Lane helpers
   // ------------------------------------------------------------
   // Bytes that one cycle moves: lowest lanes first on narrow buses
   function [3:0] take_mask;
      input [3:0] mask;
      input [1:0] size;
      begin
         take_mask = mask;
         if (size == `NBS_SIZE_8) begin
            take_mask = mask & (~mask + 4'h1);
         end else if (size == `NBS_SIZE_16) begin
            if ((mask & `NBS_MASK_LO16) != `NBS_MASK_NONE) begin
               take_mask = mask & `NBS_MASK_LO16;
            end else begin
               take_mask = mask & `NBS_MASK_HI16;
            end
         end
      end
   endfunction
   // Byte lane rotation by the doubleword offset
   function [31:0] rotl;
      input [31:0] w;
      input [1:0] off;
      reg [63:0] t;
      begin
         t = {w, w} << {off, 3'h0};
         rotl = t[63:32];
      end
   endfunction
   // ------------------------------------------------------------
   // Size pin synchronisers
   // ------------------------------------------------------------
   reg s8_meta; // First stage, read only by second
   reg s8_sync; // Second stage
   reg s16_meta; // First stage, read only by second
   reg s16_sync; // Second stage
   wire [1:0] bus_size; // Sampled size code
   // Pins come from the board, so two flops before use
   always @(posedge ref_clk) begin
      if (rst) begin
         s8_meta <= 1'b1;
         s8_sync <= 1'b1;
         s16_meta <= 1'b1;
         s16_sync <= 1'b1;
      end else begin
         s8_meta <= size8_request_n;
         s8_sync <= s8_meta;
         s16_meta <= size16_request_n;
         s16_sync <= s16_meta;
      end
   end
   // Byte size wins when both pins are low
   assign bus_size = !s8_sync ? `NBS_SIZE_8 :
                     !s16_sync ? `NBS_SIZE_16 : `NBS_SIZE_32;
   // ------------------------------------------------------------
   // Transfer state
   // ------------------------------------------------------------
   reg [1:0] state; // Sequencer state
   reg [31:2] base; // Doubleword of operand start
   reg [3:0] lo_mask; // Bytes left in base dword
   reg [3:0] hi_mask; // Bytes left in next dword
   reg [1:0] off; // Operand byte offset
   reg is_write; // Request direction
   reg is_fill; // Line fill in progress
   reg first_fill; // Next cycle is first of fill
   reg [1:0] fill_idx; // Dword within line
   reg [2:0] fill_left; // Dwords still to fill
   reg [31:0] wlanes; // Write data on lanes
   reg [31:0] lanes; // Read bytes gathered on lanes
   reg use_hi; // Current cycle is the upper dword
   wire [3:0] cur_mask; // Bytes for current cycle
   wire [31:2] cur_addr; // Address for current cycle
   wire [7:0] len_mask; // Length mask before shift
   wire [7:0] span; // Length mask placed at offset
   wire [3:0] took; // Bytes moved by finished cycle
   wire [3:0] rest; // Bytes of current dword still open
   wire [31:0] merged; // Lanes with this cycle's read data
   wire [63:0] realign; // Lanes rotated back to operand order
   wire buf_ready; // Room in cycle buffer
   wire push; // Cycle enters buffer
   wire [67:0] payload; // Buffered cycle
   genvar gi;
   // Physical dwords are four-byte aligned, so bit 0-1 pick lanes
   assign len_mask = (req_len == `NBS_LEN_4) ? `NBS_MASK_4 :
                     (req_len == `NBS_LEN_2) ? `NBS_MASK_2 : `NBS_MASK_1;
   // Bytes past the boundary spill into the next dword
   assign span = len_mask << req_addr[1:0];
   // Upper dword goes out first on a split operand
   assign cur_mask = use_hi ? hi_mask : lo_mask;
   assign cur_addr = is_fill ? {base[31:4], fill_idx} : (use_hi ? base + 30'h1 : base);
   // Within a cycle narrow buses take lowest bytes first
   assign took = take_mask(cur_mask, bus_size);
   assign rest = cur_mask & ~took;
   // Collect read bytes on the lanes that this cycle moved
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign merged[gi*8 +: 8] = took[gi] ? cyc_rdata[gi*8 +: 8] : lanes[gi*8 +: 8];
      end
   endgenerate
   // First fill cycle asks for every byte; later ones only what is missing
   assign payload = {cur_addr, ~(first_fill ? `NBS_MASK_ALL : cur_mask),
                     wlanes, is_write, first_fill};
   assign push = (state == ST_ISSUE) && buf_ready;
   // Doubled word so the shift wraps; only the low half is used
   assign realign = {merged, merged} >> {off, 3'h0};
   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // One cycle outstanding at a time; each moves at least one byte,
   // so a byte-bus fill ends within sixteen cycles
   always @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         req_ready <= 1'b1;
         base <= 30'h0;
         lo_mask <= `NBS_MASK_NONE;
         hi_mask <= `NBS_MASK_NONE;
         off <= 2'h0;
         is_write <= 1'b0;
         is_fill <= 1'b0;
         first_fill <= 1'b0;
         fill_idx <= 2'h0;
         fill_left <= 3'h0;
         wlanes <= 32'h0000_0000;
         lanes <= 32'h0000_0000;
         use_hi <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 32'h0000_0000;
         rd_last <= 1'b0;
         op_done <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         op_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (req_valid && req_ready) begin
                  // Latch the request and lay it on the lanes
                  req_ready <= 1'b0;
                  base <= req_addr[31:2];
                  off <= req_addr[1:0];
                  is_write <= req_write & ~req_fill;
                  is_fill <= req_fill;
                  first_fill <= req_fill;
                  fill_idx <= req_addr[3:2];
                  fill_left <= `NBS_FILL_DWORDS;
                  wlanes <= rotl(req_wdata, req_addr[1:0]);
                  lanes <= 32'h0000_0000;
                  lo_mask <= req_fill ? `NBS_MASK_ALL : span[3:0];
                  hi_mask <= req_fill ? `NBS_MASK_NONE : span[7:4];
                  use_hi <= ~req_fill && (span[7:4] != `NBS_MASK_NONE);
                  state <= ST_ISSUE;
               end
            end
            ST_ISSUE: begin
               // A full buffer stalls the sequencer here
               if (push) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (cyc_done) begin
                  first_fill <= 1'b0;
                  lanes <= merged;
                  if (use_hi) begin
                     hi_mask <= rest;
                  end else begin
                     lo_mask <= rest;
                  end
                  if (rest != `NBS_MASK_NONE) begin
                     // Same dword, more bytes outstanding
                     state <= ST_ISSUE;
                  end else if (is_fill) begin
                     // Dword of the line is complete
                     rd_valid <= 1'b1;
                     rd_data <= merged;
                     lanes <= 32'h0000_0000;
                     if (fill_left == 3'h1) begin
                        rd_last <= 1'b1;
                        op_done <= 1'b1;
                        req_ready <= 1'b1;
                        state <= ST_IDLE;
                     end else begin
                        fill_left <= fill_left - 3'h1;
                        fill_idx <= fill_idx + 2'h1;
                        lo_mask <= `NBS_MASK_ALL;
                        state <= ST_ISSUE;
                     end
                  end else if (use_hi) begin
                     // Upper part done, lower part follows
                     use_hi <= 1'b0;
                     state <= ST_ISSUE;
                  end else begin
                     // Operand complete, realign to low byte first
                     rd_valid <= ~is_write;
                     rd_data <= realign[31:0];
                     rd_last <= ~is_write;
                     op_done <= 1'b1;
                     req_ready <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               req_ready <= 1'b1;
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // Cycle buffer toward the bus engine
   // ------------------------------------------------------------
   nbs_buf2 u_buf (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(state == ST_ISSUE),
      .in_ready(buf_ready),
      .in_data(payload),
      .out_valid(cyc_valid),
      .out_ready(cyc_ready),
      .out_data({cyc_addr, byte_lane_enables_n, cyc_wdata, cyc_write, cyc_first_fill})
   );
endmodule // nbs_sizer

// File: testbench/nbs_bus_model.sv
// Bus engine and narrow memory standing behind the sizing block
`timescale 1ns/10ps
module nbs_bus_model (
   input wire ref_clk, // Clock
   input wire rst, // Reset
   input wire cyc_valid, // Cycle pending
   input wire [31:2] cyc_addr, // Dword address
   input wire [3:0] byte_lane_enables_n, // Enables
   input wire cyc_first_fill, // First fill cycle
   input wire [3:0] lat, // Wait cycles, also stall
   output reg cyc_ready, // Take cycle
   output reg cyc_done, // Cycle ended
   output wire [31:0] cyc_rdata // Read lanes
);
   reg busy; // Cycle outstanding
   reg [3:0] cnt; // Wait counter
   reg [31:2] addr; // Taken address
   reg [31:0] dat; // Last read dword
   wire [31:0] base = {addr, 2'h0}; // Byte base
   wire [3:0] act = ~byte_lane_enables_n; // Active lanes
   function [7:0] pat(input [31:0] a);
      pat = a[7:0] ^ 8'ha5;
   endfunction
   // Narrow decoder, unknown patterns left to the cheapest logic
   wire dec_a0 = !cyc_first_fill && !act[0] && (act[1] || act[3] && !act[2]);
   wire dec_a1 = !cyc_first_fill && !act[0] && !act[1];
   wire dec_bhe_n = !cyc_first_fill && !act[1] && !act[3];
   wire dec_ble_n = dec_a0;
   // Lines show the inverse once the cycle is over, so stale data is caught
   assign cyc_rdata = cyc_done ? dat : ~dat;
   // Engine: take, wait lat cycles, end; stall lat cycles before the next take
   always @(posedge ref_clk) begin
      if (rst) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         cyc_ready <= 1'b0;
         cyc_done <= 1'b0;
         addr <= 30'h0;
         dat <= 32'h0000_0000;
      end else begin
         cyc_done <= 1'b0;
         if (cyc_valid && cyc_ready) begin
            busy <= 1'b1;
            cyc_ready <= 1'b0;
            cnt <= lat;
            addr <= cyc_addr;
         end else if (busy) begin
            if (cnt == 4'h0) begin
               busy <= 1'b0;
               cyc_done <= 1'b1;
               cnt <= lat;
               // Full dword on processor lanes, also on a first fill cycle
               dat <= {pat(base + 3), pat(base + 2), pat(base + 1), pat(base)};
            end else begin
               cnt <= cnt - 4'h1;
            end
         end else if (cnt == 4'h0) begin
            cyc_ready <= 1'b1;
         end else begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule // nbs_bus_model

// File: testbench/nbs_properties.sv
// Port checker for the narrow bus sizing block
`timescale 1ns/10ps
module nbs_props (
   input wire ref_clk, // Clock
   input wire rst, // Reset
   input wire req_valid, // Request
   input wire req_ready, // Idle
   input wire cyc_valid, // Cycle pending
   input wire cyc_ready, // Cycle taken
   input wire [31:2] cyc_addr, // Dword address
   input wire [3:0] byte_lane_enables_n, // Enables
   input wire cyc_first_fill, // First fill cycle
   input wire cyc_done, // Cycle ended
   input wire rd_valid, // Read word
   input wire rd_last, // Last word
   input wire op_done // Request done
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // Only contiguous, non-empty enable patterns
   property p_contig;
      cyc_valid |-> byte_lane_enables_n inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h9, 4'h3,
         4'h8, 4'h1, 4'h0};
   endproperty
   a_contig: assert property (p_contig) else $error("enables not contiguous");
   property p_fill_all;
      cyc_valid && cyc_first_fill |-> byte_lane_enables_n == 4'h0;
   endproperty
   a_fill_all: assert property (p_fill_all) else $error("first fill not all lanes");
   // A first fill cycle appears two cycles after its request
   property p_fill_start;
      $rose(cyc_valid) && cyc_first_fill |-> $past(req_valid && req_ready, 2);
   endproperty
   a_fill_start: assert property (p_fill_start) else $error("first fill flag misplaced");
   property p_hold;
      cyc_valid && !cyc_ready |=> cyc_valid && $stable(cyc_addr) && $stable(byte_lane_enables_n);
   endproperty
   a_hold: assert property (p_hold) else $error("stalled cycle changed");
   property p_take;
      req_valid && req_ready |=> !req_ready ##1 cyc_valid;
   endproperty
   a_take: assert property (p_take) else $error("request take timing wrong");
   property p_done;
      op_done |-> req_ready && $past(cyc_done);
   endproperty
   a_done: assert property (p_done) else $error("op_done without cycle end");
   property p_last;
      rd_last |-> rd_valid;
   endproperty
   a_last: assert property (p_last) else $error("last without valid");
   // One cycle outstanding: nothing new right after a take or an end
   property p_gap;
      cyc_valid && cyc_ready || cyc_done |=> !cyc_valid;
   endproperty
   a_gap: assert property (p_gap) else $error("cycle issued too early");
endmodule // nbs_props
bind nbs_sizer nbs_props nbs_props_i (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
   .req_ready(req_ready), .cyc_valid(cyc_valid), .cyc_ready(cyc_ready), .cyc_addr(cyc_addr),
   .byte_lane_enables_n(byte_lane_enables_n), .cyc_first_fill(cyc_first_fill),
   .cyc_done(cyc_done), .rd_valid(rd_valid), .rd_last(rd_last), .op_done(op_done));

// File: testbench/tb.sv
// Self-checking bench for the narrow bus sizing block
`timescale 1ns/10ps
`include "nbs_map.vh"
module tb;
   reg ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, req_fill = 1'b0;
   reg size8_request_n = 1'b1, size16_request_n = 1'b1; // Bus size pins
   reg [31:0] req_addr = 32'h0000_0000, req_wdata = 32'h0000_0000;
   reg [1:0] req_len = 2'h0;
   reg [3:0] lat = 4'h0; // Engine wait cycles
   wire req_ready, cyc_valid, cyc_ready, cyc_write, cyc_first_fill, cyc_done;
   wire rd_valid, rd_last, op_done;
   wire [31:2] cyc_addr;
   wire [3:0] byte_lane_enables_n;
   wire [31:0] cyc_wdata, cyc_rdata, rd_data;
   integer err_total = 0, n_checks = 0;
   reg [3:0] en_q [$]; // Enables per taken cycle
   reg [29:0] ad_q [$]; // Address per taken cycle
   reg [31:0] wd_q [$], rd_q [$]; // Write lanes, read words
   reg ff_q [$], lt_q [$], wr_q [$]; // First fill, last and write flags
   always #25 ref_clk = ~ref_clk;
   nbs_sizer nbs_sizer_i (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_addr(req_addr), .req_len(req_len), .req_write(req_write),
      .req_fill(req_fill), .req_wdata(req_wdata), .cyc_valid(cyc_valid), .cyc_ready(cyc_ready),
      .cyc_addr(cyc_addr), .byte_lane_enables_n(byte_lane_enables_n), .cyc_write(cyc_write),
      .cyc_wdata(cyc_wdata), .cyc_first_fill(cyc_first_fill), .cyc_done(cyc_done),
      .cyc_rdata(cyc_rdata), .size8_request_n(size8_request_n),
      .size16_request_n(size16_request_n), .rd_valid(rd_valid), .rd_data(rd_data),
      .rd_last(rd_last), .op_done(op_done));
   nbs_bus_model nbs_bus_model_i (.ref_clk(ref_clk), .rst(rst), .cyc_valid(cyc_valid),
      .cyc_addr(cyc_addr), .byte_lane_enables_n(byte_lane_enables_n),
      .cyc_first_fill(cyc_first_fill), .lat(lat), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
      .cyc_rdata(cyc_rdata));
   // Far-side decoder outputs {a0, a1, high select, low select}
   wire [3:0] dec_seen = {nbs_bus_model_i.dec_a0, nbs_bus_model_i.dec_a1,
      nbs_bus_model_i.dec_bhe_n, nbs_bus_model_i.dec_ble_n};
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Decoder table per enable pattern; a first fill cycle decodes to zero
   function [3:0] dec_exp(input [3:0] en_n, input ff);
      case (~en_n & {4{~ff}})
         4'h1: dec_exp = 4'h2;
         4'h2: dec_exp = 4'h9;
         4'h4: dec_exp = 4'h6;
         4'h8: dec_exp = 4'hd;
         4'hc: dec_exp = 4'h4;
         4'h6, 4'he: dec_exp = 4'h9;
         default: dec_exp = 4'h0;
      endcase
   endfunction
   function [31:0] dw(input [31:0] b);
      dw = {b[7:0] + 8'h3, b[7:0] + 8'h2, b[7:0] + 8'h1, b[7:0]} ^ 32'ha5a5_a5a5;
   endfunction
   function [3:0] upper_n(input [1:0] k); // Lanes k..3 active
      upper_n = ~(4'hf << k);
   endfunction
   // Log every taken cycle and every read word
   always @(posedge ref_clk) begin
      if (cyc_valid === 1'b1 && cyc_ready === 1'b1) begin
         en_q.push_back(byte_lane_enables_n);
         ad_q.push_back(cyc_addr);
         wd_q.push_back(cyc_wdata);
         ff_q.push_back(cyc_first_fill);
         wr_q.push_back(cyc_write);
         chk("decode", dec_exp(byte_lane_enables_n, cyc_first_fill), dec_seen);
      end
      if (rd_valid === 1'b1) begin
         rd_q.push_back(rd_data);
         lt_q.push_back(rd_last);
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      n_checks = n_checks + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One request, sizes set first so the synchronisers settle
   task run(input s8, input s16, input [31:0] a, input [1:0] l, input w, input f,
      input [31:0] wd);
      integer i;
      size8_request_n = s8;
      size16_request_n = s16;
      repeat (4) @(posedge ref_clk);
      #1;
      en_q.delete();
      ad_q.delete();
      wd_q.delete();
      ff_q.delete();
      wr_q.delete();
      rd_q.delete();
      lt_q.delete();
      {req_addr, req_len, req_write, req_fill, req_wdata, req_valid} = {a, l, w, f, wd, 1'b1};
      @(posedge ref_clk);
      #1 req_valid = 1'b0;
      for (i = 0; i < 400 && op_done !== 1'b1; i = i + 1) begin
         @(posedge ref_clk);
         #1;
      end
      chk("op_done", 1, op_done);
      @(posedge ref_clk);
      #1;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_wide;
      integer o;
      for (o = 0; o < 4; o = o + 1) begin
         run(1, 1, 32'h0000_0200 + o, `NBS_LEN_4, 0, 0, 0);
         chk("cycles", (o == 0) ? 1 : 2, en_q.size());
         chk("first en", (o == 0) ? 0 : upper_n(o) ^ 4'hf, en_q[0]);
         if (o != 0) chk("upper addr", 30'h81, ad_q[0]);
         if (o != 0) chk("low en", upper_n(o), en_q[1]);
         chk("rd", dw(32'h0000_0200 + o), rd_q[0]);
      end
      run(1, 1, 32'h0000_0103, `NBS_LEN_2, 0, 0, 0);
      chk("en hi", 4'he, en_q[0]);
      chk("en lo", 4'h7, en_q[1]);
      chk("rd2", dw(32'h0000_0103) & 32'h0000_ffff, rd_q[0] & 32'h0000_ffff);
      run(1, 1, 32'h0000_0101, `NBS_LEN_2, 0, 0, 0);
      chk("one cycle", 1, en_q.size());
      run(1, 1, 32'h0000_0102, `NBS_LEN_1, 0, 0, 0);
      chk("byte en", 4'hb, en_q[0]);
      chk("byte rd", dw(32'h0000_0102) & 32'h0000_00ff, rd_q[0] & 32'h0000_00ff);
      chk("byte last", 1, lt_q[0]);
   endtask
   task t_half;
      run(1, 0, 32'h0000_0300, `NBS_LEN_4, 0, 0, 0);
      chk("en lo", 4'h0, en_q[0]);
      chk("en hi", 4'h3, en_q[1]);
      chk("rd", dw(32'h0000_0300), rd_q[0]);
      run(1, 0, 32'h0000_0501, `NBS_LEN_2, 1, 0, 32'h0000_bbaa);
      chk("cycles", 2, en_q.size());
      chk("en a", 4'h9, en_q[0]);
      chk("en b", 4'hb, en_q[1]);
      chk("lanes", 32'h00bb_aa00, wd_q[1] & 32'h00ff_ff00);
      chk("write", 1, wr_q[1]);
   endtask
   task t_byte;
      integer k;
      lat = 4'h3; // Slow engine, buffer held
      run(0, 1, 32'h0000_0600, `NBS_LEN_4, 0, 0, 0);
      lat = 4'h0;
      chk("cycles", 4, en_q.size());
      for (k = 0; k < 4; k = k + 1) chk("en", upper_n(k), en_q[k]);
      chk("rd", dw(32'h0000_0600), rd_q[0]);
      chk("read", 0, wr_q[3]);
   endtask
   task t_fill;
      integer k;
      run(0, 1, 32'h0000_0408, 0, 0, 1, 0);
      chk("cycles", `NBS_FILL_MAX_CYCLES, en_q.size());
      for (k = 0; k < 16; k = k + 1) begin
         chk("addr", 30'h100 + ((2 + k / 4) % 4), ad_q[k]);
         chk("en", upper_n(k % 4), en_q[k]);
         chk("first", k == 0, ff_q[k]);
      end
      chk("words", 4, rd_q.size());
      for (k = 0; k < 4; k = k + 1) begin
         chk("fill rd", dw(32'h0000_0400 + 4 * ((2 + k) % 4)), rd_q[k]);
         chk("last", k == 3, lt_q[k]);
      end
   endtask
   initial begin
      #1_000_000;
      err_total = err_total + 1;
      report_and_stop;
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1 rst = 1'b0;
      t_wide;
      t_half;
      t_byte;
      t_fill;
      report_and_stop;
   end
endmodule // tb
